//--- dv/capture_model.sv
// Capture logic that latches the primary words on the latch clock.
`timescale 1ns/10ps
module capture_model (
    // Converter output pins.
    input  wire logic       latch_clock_out,
    input  wire logic       latch_clock_oe,
    input  wire logic [9:0] primary_word_bus,
    input  wire logic       primary_word_oe,
    // Captured word and count.
    output logic      [9:0] cap_word,
    output int              cap_count
);
    initial cap_count = 0;
    always @(posedge latch_clock_out) begin
        if (latch_clock_oe && primary_word_oe) begin
            cap_word  <= primary_word_bus;
            cap_count <= cap_count + 1;
        end
    end
endmodule : capture_model

//--- dv/testbench.sv
// Self-checking bench for the dual converter output bus multiplexer.
`timescale 1ns/10ps
module testbench;
    logic        hclk = '0, hresetn = '0, sample_clk = '0, hwrite = '0;
    logic [1:0]  htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic        hreadyout, hresp, pri_oe, sec_oe, lclk, mark, lclk_oe;
    logic [9:0]  conv_a = '0, conv_b = '0, pri, sec, cap_word;
    logic [9:0]  ah [0:10];
    logic [9:0]  bh [0:10];
    int          num_errors = 0, samples_checked = 0, cap_count, n;

    always #50 hclk = ~hclk;
    always #15 sample_clk = ~sample_clk;

    dual_adc_output_bus_mux i_dual_adc_output_bus_mux (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sample_clk(sample_clk), .conv_a_word(conv_a),
        .conv_b_word(conv_b), .primary_word_bus(pri),
        .primary_word_oe(pri_oe), .secondary_word_bus(sec),
        .secondary_word_oe(sec_oe), .latch_clock_out(lclk),
        .latch_marker_out(mark), .latch_clock_oe(lclk_oe));

    capture_model i_capture_model (
        .latch_clock_out(lclk), .latch_clock_oe(lclk_oe),
        .primary_word_bus(pri), .primary_word_oe(pri_oe),
        .cap_word(cap_word), .cap_count(cap_count));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge sample_clk) begin
        for (int i = 10; i > 0; i--) begin
            ah[i] <= ah[i-1];
            bh[i] <= bh[i-1];
        end
        ah[0]  <= conv_a;
        bh[0]  <= conv_b;
        conv_a <= conv_a + 10'h1;
        conv_b <= conv_b - 10'h3;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic [31:0] a, d, input logic w);
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb

    task automatic setmode(input logic [3:0] c);
        ahb(adc_bus_pkg::CTRL_OFFSET, {28'h0, c}, 1'h1);
        repeat (6) @(posedge hclk);
        do ahb(adc_bus_pkg::STATUS_OFFSET, '0, 1'h0); while (rd[1] !== 1'h1);
    endtask : setmode

    task automatic words(input int la, lb, input logic sgl);
        logic pl;
        logic pm;
        @(negedge sample_clk);
        #5;
        pl = lclk;
        pm = mark;
        repeat (20) begin
            @(negedge sample_clk);
            #5;
            if (sgl) begin
                chk(lclk, !pl);
                chk(mark, !pm);
                chk(pri, mark ? bh[lb] : ah[la]);
            end else begin
                chk(lclk, 1'h1);
                chk(mark, !lclk);
                chk(pri, ah[la]);
                chk(sec, bh[la]);
            end
            chk(sec_oe, !sgl);
            pl = lclk;
            pm = mark;
        end
    endtask : words

    task automatic end_of_test();
        $display("num_errors %0d samples_checked %0d", num_errors,
                 samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(32'h40, 32'hf, 1'h1);
        ahb(32'h40, '0, 1'h0);
        chk(rd, 32'h0);
        ahb(adc_bus_pkg::CTRL_OFFSET, '0, 1'h0);
        chk(rd, 32'h8);
        chk({hreadyout, hresp}, 32'h2);
        chk(pri_oe, 1'h0);
        setmode(4'h2);
        chk(pri_oe, 1'h1);
        chk(lclk_oe, 1'h1);
        words(4, 4, 1'h0);
        setmode(4'h1);
        n = cap_count;
        words(8, 9, 1'h1);
        chk(cap_count > n, 1'h1);
        ahb(adc_bus_pkg::CTRL_OFFSET, 32'h4, 1'h1);
        repeat (3) @(posedge hclk);
        chk({pri_oe, sec_oe, lclk_oe}, 3'h0);
        setmode(4'h2);
        ahb(adc_bus_pkg::CTRL_OFFSET, 32'ha, 1'h1);
        repeat (3) @(posedge hclk);
        chk(pri_oe, 1'h0);
        end_of_test();
    end
endmodule : testbench

//--- logic/adc_bus_pkg.sv
// Constants and types for the dual converter output bus multiplexer.
package adc_bus_pkg;

    // Register byte offsets and widths.
    localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam int          CTRL_W        = 4;
    localparam int          STATUS_W      = 2;

    // Control register after reset: drivers disabled, dual bus, mode 0.
    localparam logic [3:0]  CTRL_RESET    = 4'h8;

    // Word width and pipeline depths in sample-clock cycles.
    localparam int          WORD_W        = 10;
    localparam int          HIST_DEPTH    = 9;
    localparam int          LAT_DUAL_SLOW = 8;
    localparam int          LAT_DUAL_FAST = 4;
    localparam int          LAT_SINGLE_A  = 8;
    localparam int          LAT_SINGLE_B  = 9;

    // Cycles after a mode change before the pipeline holds valid words.
    localparam logic [3:0]  SETTLE_MAX    = 4'hc;

    // Control fields, bit 3 down to bit 0.
    typedef struct packed {
        logic oe_n;
        logic standby_in;
        logic clock_mode;
        logic bus_select;
    } ctrl_t;

    // Link state reported back to software.
    typedef struct packed {
        logic settled;
        logic drivers_on;
    } link_status_t;

    // State of the bus-clock domain.
    typedef struct packed {
        ctrl_t        ctrl;
        logic         dp_wr;
        logic         dp_ctrl;
        logic         dp_stat;
        link_status_t stat_s1;
        link_status_t stat_s2;
    } bus_state_t;

    // State of the sample-clock domain.
    typedef struct packed {
        ctrl_t                             ctrl_s1;
        ctrl_t                             ctrl_s2;
        logic [1:0]                        mode;
        logic                              phase;
        logic [3:0]                        settle;
        logic [HIST_DEPTH-1:0][WORD_W-1:0] a_hist;
        logic [HIST_DEPTH-1:0][WORD_W-1:0] b_hist;
        logic [WORD_W-1:0]                 pri;
        logic [WORD_W-1:0]                 sec;
        logic                              marker;
        logic                              latch;
        logic                              pri_oe;
        logic                              sec_oe;
        logic                              latch_oe;
    } link_state_t;

endpackage : adc_bus_pkg

//--- logic/dual_adc_output_bus_mux.sv
// Output bus multiplexer of a dual converter with an AHB-Lite control port.
`timescale 1ns/10ps

module dual_adc_output_bus_mux (
    // Bus clock and reset.
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // AHB-Lite slave.
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // Sample clock and converter core results.
    input  wire logic                          sample_clk,
    input  wire logic [adc_bus_pkg::WORD_W-1:0] conv_a_word,
    input  wire logic [adc_bus_pkg::WORD_W-1:0] conv_b_word,
    // Output buses and latch clocks.
    output logic      [adc_bus_pkg::WORD_W-1:0] primary_word_bus,
    output logic                               primary_word_oe,
    output logic      [adc_bus_pkg::WORD_W-1:0] secondary_word_bus,
    output logic                               secondary_word_oe,
    output logic                               latch_clock_out,
    output logic                               latch_marker_out,
    output logic                               latch_clock_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    adc_bus_pkg::bus_state_t   b_q;
    adc_bus_pkg::bus_state_t   b_d;
    adc_bus_pkg::link_state_t  l_q;
    adc_bus_pkg::link_state_t  l_d;
    adc_bus_pkg::ctrl_t        lc;
    adc_bus_pkg::link_status_t link_stat;
    logic [1:0]                rst_sync_q;
    logic                      link_rst_n;
    logic                      accept;
    logic                      dual;
    logic                      fast;
    logic                      sample_en;
    logic                      settled;
    logic                      drive;

    ////////////////////////////////////////////////////////////////////////
    // Bus-clock domain: AHB-Lite slave and control register.

    assign accept    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        b_d         = b_q;
        b_d.stat_s1 = link_stat;
        b_d.stat_s2 = b_q.stat_s1;
        b_d.dp_wr   = accept && hwrite;
        b_d.dp_ctrl = accept && (haddr == adc_bus_pkg::CTRL_OFFSET);
        b_d.dp_stat = accept && (haddr == adc_bus_pkg::STATUS_OFFSET);
        if (b_q.dp_wr && b_q.dp_ctrl) begin
            b_d.ctrl = adc_bus_pkg::ctrl_t'(hwdata[adc_bus_pkg::CTRL_W-1:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_q      <= '0;
            b_q.ctrl <= adc_bus_pkg::ctrl_t'(adc_bus_pkg::CTRL_RESET);
        end else begin
            b_q <= b_d;
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (!b_q.dp_wr && b_q.dp_ctrl) begin
            hrdata = {28'h000_0000, b_q.ctrl};
        end else if (!b_q.dp_wr && b_q.dp_stat) begin
            hrdata = {30'h0000_0000, b_q.stat_s2};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample-clock domain: reset release and output pipeline.

    always_ff @(posedge sample_clk or negedge hresetn) begin
        if (!hresetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign link_rst_n = rst_sync_q[1];

    assign lc        = l_q.ctrl_s2;
    assign dual      = !lc.bus_select;
    assign fast      = dual && lc.clock_mode;
    assign sample_en = fast || !l_q.phase;
    assign settled   = (l_q.settle == adc_bus_pkg::SETTLE_MAX)
                    && ({lc.clock_mode, lc.bus_select} == l_q.mode);
    assign drive     = !lc.oe_n && !lc.standby_in;

    always_comb begin
        l_d         = l_q;
        l_d.ctrl_s1 = b_q.ctrl;
        l_d.ctrl_s2 = l_q.ctrl_s1;
        l_d.mode    = {lc.clock_mode, lc.bus_select};
        l_d.phase   = !l_q.phase;
        if (l_d.mode != l_q.mode) begin
            l_d.settle = 4'h0;
        end else if (!settled) begin
            l_d.settle = l_q.settle + 4'h1;
        end
        l_d.a_hist = {l_q.a_hist[adc_bus_pkg::HIST_DEPTH-2:0], conv_a_word};
        l_d.b_hist = {l_q.b_hist[adc_bus_pkg::HIST_DEPTH-2:0], conv_b_word};
        if (fast) begin
            l_d.pri    = l_q.a_hist[adc_bus_pkg::LAT_DUAL_FAST-1];
            l_d.sec    = l_q.b_hist[adc_bus_pkg::LAT_DUAL_FAST-1];
            l_d.marker = 1'b0;
        end else if (dual) begin
            if (sample_en) begin
                l_d.pri = l_q.a_hist[adc_bus_pkg::LAT_DUAL_SLOW-1];
                l_d.sec = l_q.b_hist[adc_bus_pkg::LAT_DUAL_SLOW-1];
            end
            l_d.marker = 1'b0;
        end else if (sample_en) begin
            l_d.pri    = l_q.a_hist[adc_bus_pkg::LAT_SINGLE_A-1];
            l_d.marker = 1'b0;
        end else begin
            l_d.pri    = l_q.b_hist[adc_bus_pkg::LAT_SINGLE_B-1];
            l_d.marker = 1'b1;
        end
        l_d.latch    = l_q.phase;
        l_d.pri_oe   = drive;
        l_d.sec_oe   = drive && dual;
        l_d.latch_oe = drive;
    end

    always_ff @(posedge sample_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_q      <= '0;
            l_q.ctrl_s1 <= adc_bus_pkg::ctrl_t'(adc_bus_pkg::CTRL_RESET);
            l_q.ctrl_s2 <= adc_bus_pkg::ctrl_t'(adc_bus_pkg::CTRL_RESET);
        end else begin
            l_q <= l_d;
        end
    end

    assign link_stat.settled    = settled;
    assign link_stat.drivers_on = l_q.pri_oe;

    ////////////////////////////////////////////////////////////////////////
    // Output pins.

    assign primary_word_bus   = l_q.pri;
    assign primary_word_oe    = l_q.pri_oe;
    assign secondary_word_bus = l_q.sec;
    assign secondary_word_oe  = l_q.sec_oe;
    assign latch_clock_oe     = l_q.latch_oe;
    // In the full-rate clock modes the latch clock is the inverted input clock.
    assign latch_clock_out    = lc.clock_mode ? !sample_clk : l_q.latch;
    assign latch_marker_out   = dual ? !latch_clock_out : l_q.marker;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    primary_hiz_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        $past(lc.standby_in) |-> !primary_word_oe)
        else $error("primary bus driven during standby");

    secondary_hiz_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        ($past(lc.standby_in) || $past(lc.bus_select)) |-> !secondary_word_oe)
        else $error("secondary bus driven in standby or single bus");

    drivers_on_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        ($past(!lc.oe_n && !lc.standby_in))
        |-> (primary_word_oe && latch_clock_oe
             && (secondary_word_oe == $past(dual))))
        else $error("drivers not enabled by low enable");

    latch_hiz_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        ($past(lc.standby_in) || $past(lc.oe_n)) |-> !latch_clock_oe)
        else $error("latch clock driven while disabled");

    half_rate_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !fast) |-> (sample_en != $past(sample_en)))
        else $error("slow modes must sample every second edge");

    fast_latency_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && fast)
        |-> (primary_word_bus == $past(conv_a_word, 5)
             && secondary_word_bus == $past(conv_b_word, 5)))
        else $error("fast dual words not four cycles late");

    slow_latency_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && dual && !fast && $past(sample_en))
        |-> (primary_word_bus == $past(conv_a_word, 9)
             && secondary_word_bus == $past(conv_b_word, 9)))
        else $error("slow dual words not eight cycles late");

    single_mux_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !dual)
        |-> (l_q.marker ? primary_word_bus == $past(conv_b_word, 10)
                        : primary_word_bus == $past(conv_a_word, 9)))
        else $error("single bus word or marker wrong");

    marker_toggle_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !dual) |=> (l_q.marker != $past(l_q.marker)))
        else $error("channel marker does not alternate");

    slow_latch_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !lc.clock_mode)
        |-> (latch_clock_out != $past(latch_clock_out)))
        else $error("slow latch clock not at half rate");

    ////////////////////////////////////////////////////////////////////////
    // Checks on settling, word timing, latch clocks, pin enables and the control port.

    mode_settle_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        ({lc.clock_mode, lc.bus_select} != l_q.mode)
        |=> (l_q.settle == 4'h0))
        else $error("mode change does not restart settling");

    fast_sample_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        fast |-> sample_en)
        else $error("fast dual mode skips a sample edge");

    dual_marker_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && dual) |-> !l_q.marker)
        else $error("dual bus word marked as channel B");

    single_sec_off_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !dual) |-> !secondary_word_oe)
        else $error("secondary bus driven in single bus");

    fast_latch_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        lc.clock_mode |-> latch_clock_out)
        else $error("full-rate latch clock not the inverted input clock");

    inv_latch_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        dual |-> (latch_marker_out != latch_clock_out))
        else $error("complementary latch clock not inverted");

    single_a_word_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !dual && $past(sample_en))
        |-> (primary_word_bus == $past(conv_a_word, 9)))
        else $error("single bus A word not eight cycles late");

    single_b_word_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && !dual && $past(!sample_en))
        |-> (primary_word_bus == $past(conv_b_word, 10)))
        else $error("single bus B word not nine cycles late");

    slow_hold_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && dual && !fast && $past(!sample_en))
        |-> ($stable(primary_word_bus) && $stable(secondary_word_bus)))
        else $error("slow dual words change between samples");

    msb_order_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        (settled && fast)
        |-> (primary_word_bus[9] == $past(conv_a_word[9], 5)))
        else $error("primary bus bit order wrong");

    standby_off_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        $past(lc.standby_in)
        |-> !(primary_word_oe || secondary_word_oe || latch_clock_oe))
        else $error("outputs driven while powered down");

    oe_high_off_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        $past(lc.oe_n) |-> !(primary_word_oe || secondary_word_oe))
        else $error("data outputs driven with enable high");

    primary_on_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        $past(drive)
        |-> primary_word_oe)
        else $error("primary bus not driven when enabled");

    latch_pin_on_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        $past(drive) |-> latch_clock_oe)
        else $error("latch clock not driven when enabled");

    dual_sec_on_a : assert property (
        @(posedge sample_clk) disable iff (!link_rst_n)
        ($past(drive) && $past(!lc.bus_select))
        |-> secondary_word_oe)
        else $error("secondary bus not driven in dual bus");

    ctrl_write_a : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (b_q.dp_wr && b_q.dp_ctrl)
        |=> (b_q.ctrl == $past(hwdata[adc_bus_pkg::CTRL_W-1:0])))
        else $error("control write not stored");

    read_zero_a : assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!b_q.dp_ctrl && !b_q.dp_stat) |-> (hrdata == 32'h0000_0000))
        else $error("read data not zero outside a register read");

endmodule : dual_adc_output_bus_mux
